// ---- logic/irq_reset_pkg.sv ----
`default_nettype none
package irq_reset_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned RESET_WAIT_CYCLES = 16;
  localparam logic [4:0]  WAIT_CNT_LAST     = 5'h0F;
  localparam logic [4:0]  WAIT_CNT_ZERO     = 5'h00;
  localparam logic [15:0] START_ADDR        = 16'h0000;

  // ****************************************
  // Interrupt flag and mask bit positions
  // ****************************************
  localparam int unsigned IRQ_BITS    = 3;
  localparam int unsigned BIT_ONE     = 0;
  localparam int unsigned BIT_TWO     = 1;
  localparam int unsigned BIT_THREE   = 2;
  localparam logic [2:0]  IRQ_NONE    = 3'h0;
  localparam logic [2:0]  MASK_RESET  = 3'h0;
  localparam logic        MODE_HOLD   = 1'b0;

  // ****************************************
  // Vector codes to the trap logic
  // ****************************************
  localparam logic [2:0] VEC_NONE  = 3'h0;
  localparam logic [2:0] VEC_NMI   = 3'h1;
  localparam logic [2:0] VEC_ONE   = 3'h2;
  localparam logic [2:0] VEC_TWO   = 3'h3;
  localparam logic [2:0] VEC_THREE = 3'h4;

  // ****************************************
  // Sequencer states (Gray along the path)
  // ****************************************
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] vector;
  } trap_req_s;

  typedef struct packed {
    logic       load_pc;
    logic       boot_loader;
    logic       fetch_en;
  } cpu_ctrl_s;
endpackage
`default_nettype wire

// ---- logic/irq_reset_ctrl.sv ----
// Functional notes
// - While reset is asserted, execution stops and the program counter is forced to zero.
// - After reset release the block waits 16 cycles, then fetching starts at address 0.
// - With boot select high, execution runs straight from off-chip memory with no boot loader.
// - With boot select low, the boot loader copies global data space into external program RAM.
// - The non-maskable interrupt is taken whatever the global disable bit and the masks say.
// - The non-maskable interrupt traps to its own vector.
// - The shared hold / interrupt-one pin is an interrupt source in both of its uses.
// - Mode bit at 0 makes the shared pin a hold request serviced with idle; reset clears it.
// - User interrupts two and three are prioritised, individually masked and globally disabled.
// - Pending flags of interrupts two and three can be read and cleared by software.
// - In hold the block acknowledges and floats address, data and memory control outputs.
`default_nettype none
module irq_reset_ctrl
  import irq_reset_pkg::*;
(
  // Clock and core reset
  input  wire logic                    CLK_I,
  input  wire logic                    RESET_I,
  // External pins, active low except boot select
  input  wire logic                    RESET_INPUT_N_I,
  input  wire logic                    BOOT_SEL_I,
  input  wire logic                    NMI_N_I,
  input  wire logic                    EXT_IRQ_ONE_N_I,
  input  wire logic                    EXT_IRQ_TWO_N_I,
  input  wire logic                    EXT_IRQ_THREE_N_I,
  // Control bits from the CPU
  input  wire logic                    GLOBAL_IRQ_DISABLE_I,
  input  wire logic [IRQ_BITS-1:0]     IRQ_MASK_WR_DATA_I,
  input  wire logic                    IRQ_MASK_WR_I,
  input  wire logic [IRQ_BITS-1:0]     IRQ_FLAG_CLR_I,
  input  wire logic                    IRQ_CONTROL_MODE_I,
  input  wire logic                    IRQ_CONTROL_WR_I,
  input  wire logic                    IDLE_I,
  input  wire logic                    TRAP_TAKEN_I,
  // Status and control out
  output logic [IRQ_BITS-1:0]          IRQ_FLAG_REG_O,
  output logic [IRQ_BITS-1:0]          IRQ_MASK_REG_O,
  output logic                         IRQ_CONTROL_MODE_O,
  output irq_reset_pkg::trap_req_s     TRAP_REQ_O,
  output irq_reset_pkg::cpu_ctrl_s     CPU_CTRL_O,
  output logic [15:0]                  PC_FORCE_O,
  output logic                         BUS_RELEASE_ACK_N_O,
  output logic                         BUS_OE_O
);
  import irq_reset_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;
  wire  [4:0] pins_n = {RESET_INPUT_N_I, NMI_N_I, EXT_IRQ_ONE_N_I, EXT_IRQ_TWO_N_I, EXT_IRQ_THREE_N_I};

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
      prev_reg  <= 5'h1F;
    end else begin
      sync1_reg <= pins_n;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire reset_act  = ~sync2_reg[4];
  wire nmi_fall   = prev_reg[3] & ~sync2_reg[3];
  wire one_fall   = prev_reg[2] & ~sync2_reg[2];
  wire two_fall   = prev_reg[1] & ~sync2_reg[1];
  wire three_fall = prev_reg[0] & ~sync2_reg[0];
  wire one_level  = ~sync2_reg[2];

  // ****************************************
  // Reset sequencer
  // ****************************************
  seq_state_e state_reg;
  seq_state_e state_next;
  logic [4:0] cnt_reg;
  wire        wait_done = (cnt_reg == WAIT_CNT_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HALT: state_next = ST_WAIT;
      ST_WAIT: if (wait_done) begin
        state_next = ST_RUN;
      end
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_HALT;
    endcase
    if (reset_act) begin
      state_next = ST_HALT;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_HALT;
      cnt_reg   <= WAIT_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next == ST_WAIT && state_reg == ST_WAIT) ? cnt_reg + 5'h01 : WAIT_CNT_ZERO;
    end
  end

  wire running = (state_next == ST_RUN);
  wire halted  = (state_next != ST_RUN);

  // ****************************************
  // Mask, mode and flags
  // ****************************************
  logic [IRQ_BITS-1:0] mask_reg;
  logic [IRQ_BITS-1:0] flag_reg;
  logic [IRQ_BITS-1:0] flag_next;
  logic                mode_reg;
  logic                nmi_pend_reg;
  logic                hold_reg;

  wire [IRQ_BITS-1:0] flag_set = {three_fall, two_fall, one_fall};
  wire [IRQ_BITS-1:0] pend_en  = flag_reg & mask_reg & {IRQ_BITS{~GLOBAL_IRQ_DISABLE_I}};

  // Shown values follow the pin reset clear
  wire [IRQ_BITS-1:0] flag_shown = reset_act ? IRQ_NONE : flag_next;
  wire [IRQ_BITS-1:0] mask_shown = reset_act ? MASK_RESET : (IRQ_MASK_WR_I ? IRQ_MASK_WR_DATA_I : mask_reg);
  wire                mode_shown = reset_act ? MODE_HOLD : (IRQ_CONTROL_WR_I ? IRQ_CONTROL_MODE_I : mode_reg);

  always_comb begin
    flag_next = (flag_reg & ~IRQ_FLAG_CLR_I) | flag_set;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I || reset_act) begin
      mask_reg     <= MASK_RESET;
      mode_reg     <= MODE_HOLD;
      flag_reg     <= IRQ_NONE;
      nmi_pend_reg <= 1'b0;
    end else begin
      if (IRQ_MASK_WR_I) begin
        mask_reg <= IRQ_MASK_WR_DATA_I;
      end
      if (IRQ_CONTROL_WR_I) begin
        mode_reg <= IRQ_CONTROL_MODE_I;
      end
      flag_reg     <= flag_next;
      nmi_pend_reg <= nmi_fall | (nmi_pend_reg & ~(TRAP_TAKEN_I && TRAP_REQ_O.vector == VEC_NMI));
    end
  end

  // ****************************************
  // Trap priority: NMI, one, two, three
  // ****************************************
  function automatic logic [2:0] pick_vec(input logic nmi, input logic [IRQ_BITS-1:0] en);
    if (nmi)                 return VEC_NMI;
    else if (en[BIT_ONE])    return VEC_ONE;
    else if (en[BIT_TWO])    return VEC_TWO;
    else if (en[BIT_THREE])  return VEC_THREE;
    else                     return VEC_NONE;
  endfunction

  wire [2:0] vec_sel = pick_vec(nmi_pend_reg, pend_en);

  // ****************************************
  // Hold: idle with pin low in hold mode
  // ****************************************
  wire hold_next = running & (mode_reg == MODE_HOLD) & one_level & (hold_reg | IDLE_I);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      hold_reg            <= 1'b0;
      TRAP_REQ_O          <= '0;
      CPU_CTRL_O          <= '0;
      PC_FORCE_O          <= START_ADDR;
      BUS_RELEASE_ACK_N_O <= 1'b1;
      BUS_OE_O            <= 1'b0;
      IRQ_FLAG_REG_O      <= IRQ_NONE;
      IRQ_MASK_REG_O      <= MASK_RESET;
      IRQ_CONTROL_MODE_O  <= MODE_HOLD;
    end else begin
      hold_reg               <= hold_next;
      TRAP_REQ_O.valid       <= running & (vec_sel != VEC_NONE);
      TRAP_REQ_O.vector      <= running ? vec_sel : VEC_NONE;
      CPU_CTRL_O.load_pc     <= halted;
      CPU_CTRL_O.fetch_en    <= running & ~hold_next;
      CPU_CTRL_O.boot_loader <= running & ~BOOT_SEL_I;
      PC_FORCE_O             <= START_ADDR;
      BUS_RELEASE_ACK_N_O    <= ~hold_next;
      BUS_OE_O               <= ~hold_next;
      IRQ_FLAG_REG_O         <= flag_shown;
      IRQ_MASK_REG_O         <= mask_shown;
      IRQ_CONTROL_MODE_O     <= mode_shown;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence reset_seen;
    reset_act;
  endsequence

  sequence release_seen;
    $fell(reset_act);
  endsequence

  // Release edge, one cycle in ST_HALT, then the full wait count
  localparam int RUN_DELAY = RESET_WAIT_CYCLES + 1;

  chk_reset_halts: assert property (@(posedge CLK_I) disable iff (RESET_I)
    reset_seen |=> CPU_CTRL_O.load_pc && !CPU_CTRL_O.fetch_en)
    else $error("fetch active during reset");
  chk_wait_sixteen: assert property (@(posedge CLK_I) disable iff (RESET_I || reset_act)
    release_seen |-> ##RUN_DELAY state_reg == ST_RUN)
    else $error("run not reached after reset wait");
  chk_wait_not_early: assert property (@(posedge CLK_I) disable iff (RESET_I)
    release_seen |=> !CPU_CTRL_O.fetch_en [*8])
    else $error("fetch started too early");
  chk_boot_direct: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (running && BOOT_SEL_I) |=> !CPU_CTRL_O.boot_loader)
    else $error("boot loader used with boot select high");
  chk_boot_loader: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (running && !BOOT_SEL_I) |=> CPU_CTRL_O.boot_loader)
    else $error("boot loader missing with boot select low");
  chk_nmi_unmasked: assert property (@(posedge CLK_I) disable iff (RESET_I || reset_act)
    (nmi_pend_reg && running) |=> TRAP_REQ_O.valid)
    else $error("nmi not requested");
  chk_nmi_vector: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (nmi_pend_reg && running) |=> TRAP_REQ_O.vector == VEC_NMI)
    else $error("nmi wrong vector");
  chk_one_flag: assert property (@(posedge CLK_I) disable iff (RESET_I || reset_act)
    one_fall |=> flag_reg[BIT_ONE])
    else $error("pin one event lost");
  chk_mode_reset: assert property (@(posedge CLK_I)
    RESET_I |=> IRQ_CONTROL_MODE_O == MODE_HOLD)
    else $error("mode not cleared by reset");
  chk_mask_gate: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (GLOBAL_IRQ_DISABLE_I && !nmi_pend_reg) |=> !TRAP_REQ_O.valid)
    else $error("masked interrupt requested");
  chk_flag_clear: assert property (@(posedge CLK_I) disable iff (RESET_I || reset_act)
    (IRQ_FLAG_CLR_I[BIT_TWO] && !two_fall) |=> !flag_reg[BIT_TWO])
    else $error("flag two not cleared");
  chk_mode_no_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (mode_reg != MODE_HOLD) |=> BUS_RELEASE_ACK_N_O && BUS_OE_O)
    else $error("hold taken in interrupt mode");
  chk_hold_float: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !BUS_RELEASE_ACK_N_O |-> !BUS_OE_O && !CPU_CTRL_O.fetch_en)
    else $error("bus driven during hold");
  chk_sync_delay: assert property (@(posedge CLK_I) disable iff (RESET_I)
    $fell(sync2_reg[4]) |-> $past(sync1_reg[4]) == 1'b0)
    else $error("reset pin not synchronised");
endmodule
`default_nettype wire

// ---- dv/irq_pin_model.sv ----
`default_nettype none
module irq_pin_model (
  // Clock
  input  wire logic       clk_i,
  // Pins: reset, nmi, three, two, one
  output var  logic [4:0] pins_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Idle high, every source pulls low
  // ****************************************
  initial pins_n_o = 5'h1F;
  task automatic drive(input logic [4:0] v);
    @(negedge clk_i);
    pins_n_o = v;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_irq_reset_ctrl.sv ----
`default_nettype none
module test_irq_reset_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_reset_pkg::*;
  logic clk, rst, boot, gdis, mwr, mode, cwr, idle, taken;
  logic [2:0] mdat, fclr, flags, mask;
  logic [4:0] pins_n;
  logic mode_o, ack_n, oe;
  logic [15:0] pc;
  trap_req_s trap;
  cpu_ctrl_s ctrl;
  int miscompares = 0;
  int cmp_count = 0;
  irq_pin_model partner (.clk_i(clk), .pins_n_o(pins_n));
  irq_reset_ctrl DUT (
    .CLK_I(clk), .RESET_I(rst), .RESET_INPUT_N_I(pins_n[4]), .BOOT_SEL_I(boot),
    .NMI_N_I(pins_n[3]), .EXT_IRQ_ONE_N_I(pins_n[0]), .EXT_IRQ_TWO_N_I(pins_n[1]),
    .EXT_IRQ_THREE_N_I(pins_n[2]), .GLOBAL_IRQ_DISABLE_I(gdis), .IRQ_MASK_WR_DATA_I(mdat),
    .IRQ_MASK_WR_I(mwr), .IRQ_FLAG_CLR_I(fclr), .IRQ_CONTROL_MODE_I(mode),
    .IRQ_CONTROL_WR_I(cwr), .IDLE_I(idle), .TRAP_TAKEN_I(taken), .IRQ_FLAG_REG_O(flags),
    .IRQ_MASK_REG_O(mask), .IRQ_CONTROL_MODE_O(mode_o), .TRAP_REQ_O(trap), .CPU_CTRL_O(ctrl),
    .PC_FORCE_O(pc), .BUS_RELEASE_ACK_N_O(ack_n), .BUS_OE_O(oe));
  // ****************************************
  // Clock, compare and closing
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic pin_reset(input logic sel);
    int n;
    boot = sel;
    partner.drive(5'h0F);
    tick(4);
    check({13'h0, ctrl.load_pc, ctrl.fetch_en, 1'b0}, 16'h0004);
    check(pc, START_ADDR);
    partner.drive(5'h1F);
    n = 0;
    while (ctrl.fetch_en !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check({15'h0, n >= 17 && n <= 21}, 16'h0001);
    check({15'h0, ctrl.boot_loader}, {15'h0, ~sel});
  endtask
  task automatic write_mask(input logic [2:0] v);
    mdat = v;
    mwr = 1'b1;
    tick(1);
    mwr = 1'b0;
    check({13'h0, mask}, {13'h0, v});
  endtask
  task automatic clear_flags(input logic [2:0] v);
    fclr = v;
    tick(1);
    fclr = 3'h0;
    tick(1);
  endtask
  task automatic hold_cycle();
    check({15'h0, mode_o}, {15'h0, MODE_HOLD});
    idle = 1'b1;
    partner.drive(5'h1E);
    tick(5);
    check({14'h0, ack_n, oe}, 16'h0000);
    check({13'h0, flags}, 16'h0001);
    idle = 1'b0;
    partner.drive(5'h1F);
    tick(4);
    check({14'h0, ack_n, oe}, 16'h0003);
    clear_flags(3'h7);
  endtask
  task automatic irq_mode();
    mode = 1'b1;
    cwr = 1'b1;
    tick(1);
    cwr = 1'b0;
    check({15'h0, mode_o}, 16'h0001);
    idle = 1'b1;
    partner.drive(5'h1E);
    tick(5);
    check({14'h0, ack_n, oe}, 16'h0003);
    check({13'h0, flags}, 16'h0001);
    idle = 1'b0;
    partner.drive(5'h1F);
    clear_flags(3'h7);
    mode = 1'b0;
    cwr = 1'b1;
    tick(1);
    cwr = 1'b0;
    check({15'h0, mode_o}, {15'h0, MODE_HOLD});
  endtask
  task automatic nmi_trap();
    gdis = 1'b1;
    write_mask(3'h0);
    partner.drive(5'h17);
    tick(6);
    check({12'h0, trap}, {12'h0, 1'b1, VEC_NMI});
    taken = 1'b1;
    partner.drive(5'h1F);
    taken = 1'b0;
    tick(3);
    check({15'h0, trap.valid}, 16'h0000);
  endtask
  task automatic user_irqs();
    gdis = 1'b0;
    write_mask(3'h6);
    partner.drive(5'h19);
    tick(6);
    check({13'h0, flags}, 16'h0006);
    check({12'h0, trap}, {12'h0, 1'b1, VEC_TWO});
    gdis = 1'b1;
    tick(2);
    check({15'h0, trap.valid}, 16'h0000);
    gdis = 1'b0;
    clear_flags(3'h2);
    check({13'h0, flags}, 16'h0004);
    check({12'h0, trap}, {12'h0, 1'b1, VEC_THREE});
    write_mask(3'h2);
    tick(2);
    check({15'h0, trap.valid}, 16'h0000);
    partner.drive(5'h1F);
    clear_flags(3'h7);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    boot = 1'b0;
    gdis = 1'b0;
    mwr = 1'b0;
    mode = 1'b0;
    cwr = 1'b0;
    idle = 1'b0;
    taken = 1'b0;
    mdat = 3'h0;
    fclr = 3'h0;
    tick(16);
    rst = 1'b0;
    tick(2);
    pin_reset(1'b0);
    pin_reset(1'b1);
    hold_cycle();
    irq_mode();
    nmi_trap();
    user_irqs();
    summarize();
  end
endmodule
`default_nettype wire
